//--- src/rpfs_core.sv
`timescale 1ns/10ps
module rpfs_core (
	input  wire logic              core_clk,                 // Radio core clock
	input  wire logic              rst,                      // Synchronous reset
	input  wire logic              primary_transmitter_role, // Transmitter role selected
	input  wire logic              chip_enable,              // Radio chip enable from host
	input  wire logic              host_cmd_valid,           // Command strobe
	input  wire rpfs_pkg::rpfs_cmd_t host_cmd,               // Command code
	input  wire logic [2:0]        ack_pipe_number,          // Pipe for ack payload
	input  wire logic [7:0]        host_cmd_wdata,           // Status write value
	input  wire logic              host_data_valid,          // Payload byte offered
	input  wire logic [7:0]        host_data,                // Payload byte
	input  wire logic              host_data_last,           // Last byte of payload
	output logic                   host_data_ready,          // Payload byte taken
	output logic [7:0]             status,                   // Occupancy status
	output logic                   link_tx_valid,            // Transmit byte ready
	output logic [7:0]             link_tx_data,             // Transmit byte
	output logic                   link_tx_last,             // Last transmit byte
	input  wire logic              link_tx_ready,            // Link takes a byte
	input  wire logic              link_tx_done,             // Payload sent and acked
	output logic                   link_reuse,               // Reuse mode active
	output logic                   link_retransmit,          // Send last payload again
	input  wire logic              link_rx_push,             // Payload received
	input  wire logic              link_ack_req,             // Ack due on a pipe
	input  wire logic [2:0]        link_ack_pipe,            // Pipe of that ack
	output logic                   link_ack_attach,          // Loaded payload attached
	output logic [2:0]             link_ack_attach_pipe      // Pipe it was attached to
);

	// ----------------------------------------------------------------
	// Staging buffer between host bytes and the link
	// ----------------------------------------------------------------
	rpfs_stage_if #(.WIDTH(rpfs_pkg::STAGE_W)) stg ();

	rpfs_stage_fifo #(
		.WIDTH (rpfs_pkg::STAGE_W),
		.DEPTH (rpfs_pkg::STAGE_DEPTH)
	) u_stage (
		.core_clk (core_clk),
		.rst      (rst),
		.stg      (stg.buf_side)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	rpfs_pkg::rpfs_state_t  state, next_state;               // Payload load phase
	logic [1:0]             tx_cnt, next_tx_cnt;             // Transmit entries held
	logic [1:0]             rx_cnt, next_rx_cnt;             // Receive entries held
	logic [5:0]             byte_cnt, next_byte_cnt;         // Bytes of current load
	logic                   reuse, next_reuse;               // Reuse mode
	logic [rpfs_pkg::CE_CNT_W-1:0] ce_cnt, next_ce_cnt;      // Chip-enable hold time
	logic                   retx, next_retx;                 // Retransmit pulse
	logic [5:0]             ack_loaded, next_ack_loaded;     // Ack payload per pipe
	logic                   attach, next_attach;             // Attach pulse
	logic [2:0]             attach_pipe, next_attach_pipe;   // Attach pipe number
	logic [1:0]             rsv, next_rsv;                   // Reserved status field
	logic                   tx_full, next_tx_full;           // Registered flags
	logic                   tx_empty, next_tx_empty;
	logic                   rx_full, next_rx_full;
	logic                   rx_empty, next_rx_empty;

	// ----------------------------------------------------------------
	// Decoded strobes
	// ----------------------------------------------------------------
	logic cmd_wr_tx;    // Start of a payload load
	logic cmd_flush_tx; // Drop every transmit entry
	logic cmd_flush_rx; // Drop every receive entry
	logic cmd_rd_rx;    // Host takes a receive entry
	logic capped;       // Load already reached its byte limit
	logic byte_take;    // Host byte accepted
	logic commit;       // Last byte closes an entry
	logic tx_pop;       // Link retires an entry
	logic rx_push;      // Link stores an entry
	logic rx_pop;       // Host retires an entry

	assign cmd_wr_tx    = host_cmd_valid && (host_cmd == rpfs_pkg::RPFS_CMD_WR_TX);
	assign cmd_flush_tx = host_cmd_valid && (host_cmd == rpfs_pkg::RPFS_CMD_FLUSH_TX);
	assign cmd_flush_rx = host_cmd_valid && (host_cmd == rpfs_pkg::RPFS_CMD_FLUSH_RX);
	assign cmd_rd_rx    = host_cmd_valid && (host_cmd == rpfs_pkg::RPFS_CMD_RD_RX);
	assign capped       = (byte_cnt == rpfs_pkg::PLD_MAX);

	// ----------------------------------------------------------------
	// Host byte path into the staging buffer
	// ----------------------------------------------------------------
	// entry byte limit
	// Bytes past the limit are swallowed until the host's last byte,
	// so an overlong load still closes as one 32-byte entry.
	assign stg.in_valid = host_data_valid && (state == rpfs_pkg::RPFS_LOAD) && !capped;
	assign stg.in_data  = {host_data_last || (byte_cnt == rpfs_pkg::PLD_MAX - 6'h01),
		host_data};
	assign stg.flush    = cmd_flush_tx;

	// Back-pressure from the buffer reaches the host
	assign host_data_ready = (state == rpfs_pkg::RPFS_LOAD) && (capped || stg.in_ready);
	assign byte_take       = host_data_valid && host_data_ready;
	assign commit          = byte_take && host_data_last;

	// ----------------------------------------------------------------
	// Link side of the staging buffer
	// ----------------------------------------------------------------
	assign link_tx_valid = stg.out_valid;
	assign link_tx_data  = stg.out_data[7:0];
	assign link_tx_last  = stg.out_data[8];
	assign stg.out_ready = link_tx_ready;

	// A reused payload stays in place; the link keeps its own copy
	assign tx_pop  = link_tx_done && !reuse && (tx_cnt != 2'h0);
	assign rx_push = link_rx_push && (rx_cnt != rpfs_pkg::RX_DEPTH);
	assign rx_pop  = cmd_rd_rx && (rx_cnt != 2'h0);

	// ----------------------------------------------------------------
	// Load sequence and occupancy counts
	// ----------------------------------------------------------------
	always_comb begin
		next_state    = state;
		next_byte_cnt = byte_cnt;
		next_tx_cnt   = tx_cnt;
		next_rx_cnt   = rx_cnt;
		case (state)
			// Waiting for a load command
			rpfs_pkg::RPFS_IDLE: begin
				// refuse a load when all three entries are used
				if (cmd_wr_tx && (tx_cnt != rpfs_pkg::TX_DEPTH)) begin
					next_state    = rpfs_pkg::RPFS_LOAD;
					next_byte_cnt = 6'h00;
				end
			end
			// Taking bytes of one payload
			rpfs_pkg::RPFS_LOAD: begin
				if (byte_take && !capped) begin
					next_byte_cnt = byte_cnt + 6'h01;
				end
				if (commit) begin
					next_state = rpfs_pkg::RPFS_IDLE;
				end
			end
			default: begin
				next_state = rpfs_pkg::RPFS_IDLE;
			end
		endcase
		// entry counted at its last byte
		if (commit && !tx_pop) begin
			next_tx_cnt = tx_cnt + 2'h1;
		end else if (tx_pop && !commit) begin
			next_tx_cnt = tx_cnt - 2'h1;
		end
		// Flush ends any load in progress too
		if (cmd_flush_tx) begin
			next_state  = rpfs_pkg::RPFS_IDLE;
			next_tx_cnt = 2'h0;
		end
		if (cmd_flush_rx) begin
			next_rx_cnt = 2'h0;
		end else if (rx_push && !rx_pop) begin
			next_rx_cnt = rx_cnt + 2'h1;
		end else if (rx_pop && !rx_push) begin
			next_rx_cnt = rx_cnt - 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// Reuse mode and retransmit timing
	// ----------------------------------------------------------------
	always_comb begin
		next_reuse  = reuse;
		next_ce_cnt = ce_cnt;
		next_retx   = 1'b0;
		// reuse only taken in the transmitter role
		if (host_cmd_valid && (host_cmd == rpfs_pkg::RPFS_CMD_REUSE_TX)
			&& primary_transmitter_role) begin
			next_reuse = 1'b1;
		end
		// payload write or flush ends reuse
		if (cmd_wr_tx || cmd_flush_tx) begin
			next_reuse = 1'b0;
		end
		// chip enable must stay high 10us
		// One retransmit per chip-enable pulse; the count saturates so a
		// long pulse never fires twice.
		if (!(reuse && primary_transmitter_role && chip_enable)) begin
			next_ce_cnt = '0;
		end else if (ce_cnt != rpfs_pkg::CE_CNT_W'(rpfs_pkg::CE_MIN_CYC)) begin
			next_ce_cnt = ce_cnt + 1'b1;
			if (ce_cnt == rpfs_pkg::CE_CNT_W'(rpfs_pkg::CE_MIN_CYC - 1)) begin
				next_retx = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Acknowledgement payloads per pipe
	// ----------------------------------------------------------------
	always_comb begin
		next_ack_loaded  = ack_loaded;
		next_attach      = 1'b0;
		next_attach_pipe = attach_pipe;
		// consume the loaded payload on its own pipe
		if (link_ack_req && (link_ack_pipe < rpfs_pkg::PIPES)
			&& ack_loaded[link_ack_pipe]) begin
			next_ack_loaded[link_ack_pipe] = 1'b0;
			next_attach                    = 1'b1;
			next_attach_pipe               = link_ack_pipe;
		end
		// load by command naming the pipe; set wins
		if (host_cmd_valid && (host_cmd == rpfs_pkg::RPFS_CMD_WR_ACK)
			&& (ack_pipe_number < rpfs_pkg::PIPES)) begin
			next_ack_loaded[ack_pipe_number] = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Status flags and writable field
	// ----------------------------------------------------------------
	always_comb begin
		next_rsv = rsv;
		// host keeps this field at zero; stored as written
		if (host_cmd_valid && (host_cmd == rpfs_pkg::RPFS_CMD_WR_STATUS)) begin
			next_rsv = host_cmd_wdata[rpfs_pkg::RSV_MSB:rpfs_pkg::RSV_LSB];
		end
		// full when no free transmit location
		next_tx_full  = (next_tx_cnt == rpfs_pkg::TX_DEPTH);
		next_tx_empty = (next_tx_cnt == 2'h0);
		// full when every receive location used
		next_rx_full  = (next_rx_cnt == rpfs_pkg::RX_DEPTH);
		next_rx_empty = (next_rx_cnt == 2'h0);
	end

	// Status byte assembled from registered fields only
	always_comb begin
		status                          = 8'h00;
		status[rpfs_pkg::REUSE_BIT]     = reuse;
		status[rpfs_pkg::TX_FULL_BIT]   = tx_full;
		status[rpfs_pkg::TX_EMPTY_BIT]  = tx_empty;
		status[rpfs_pkg::RSV_MSB:rpfs_pkg::RSV_LSB] = rsv;
		status[rpfs_pkg::RX_FULL_BIT]   = rx_full;
		status[rpfs_pkg::RX_EMPTY_BIT]  = rx_empty;
	end

	assign link_reuse           = reuse;
	assign link_retransmit      = retx;
	assign link_ack_attach      = attach;
	assign link_ack_attach_pipe = attach_pipe;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state       <= rpfs_pkg::RPFS_IDLE;
			byte_cnt    <= 6'h00;
			tx_cnt      <= 2'h0;
			rx_cnt      <= 2'h0;
			reuse       <= rpfs_pkg::REUSE_RST;
			ce_cnt      <= '0;
			retx        <= 1'b0;
			ack_loaded  <= 6'h00;
			attach      <= 1'b0;
			attach_pipe <= 3'h0;
			rsv         <= rpfs_pkg::RSV_RST;
			tx_full     <= rpfs_pkg::TX_FULL_RST;
			tx_empty    <= rpfs_pkg::TX_EMPTY_RST;
			rx_full     <= rpfs_pkg::RX_FULL_RST;
			rx_empty    <= rpfs_pkg::RX_EMPTY_RST;
		end else begin
			state       <= next_state;
			byte_cnt    <= next_byte_cnt;
			tx_cnt      <= next_tx_cnt;
			rx_cnt      <= next_rx_cnt;
			reuse       <= next_reuse;
			ce_cnt      <= next_ce_cnt;
			retx        <= next_retx;
			ack_loaded  <= next_ack_loaded;
			attach      <= next_attach;
			attach_pipe <= next_attach_pipe;
			rsv         <= next_rsv;
			tx_full     <= next_tx_full;
			tx_empty    <= next_tx_empty;
			rx_full     <= next_rx_full;
			rx_empty    <= next_rx_empty;
		end
	end

endmodule

//--- src/rpfs_pkg.sv
package rpfs_pkg;

	// ----------------------------------------------------------------
	// Status register field positions
	// ----------------------------------------------------------------
	localparam int STAT_W       = 8;
	localparam int REUSE_BIT    = 6;
	localparam int TX_FULL_BIT  = 5;
	localparam int TX_EMPTY_BIT = 4;
	localparam int RSV_MSB      = 3;
	localparam int RSV_LSB      = 2;
	localparam int RX_FULL_BIT  = 1;
	localparam int RX_EMPTY_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic       REUSE_RST    = 1'h0;
	localparam logic       TX_FULL_RST  = 1'h0;
	localparam logic       TX_EMPTY_RST = 1'h1;
	localparam logic [1:0] RSV_RST      = 2'h0;
	localparam logic       RX_FULL_RST  = 1'h0;
	localparam logic       RX_EMPTY_RST = 1'h1;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] TX_DEPTH    = 2'h3;
	localparam logic [1:0] RX_DEPTH    = 2'h3;
	localparam logic [5:0] PLD_MAX     = 6'h20;
	localparam logic [2:0] PIPES       = 3'h6;
	localparam int         STAGE_W     = 9;
	localparam int         STAGE_DEPTH = 16;

	// ----------------------------------------------------------------
	// Timing: least chip-enable hold for a reuse retransmit
	// ----------------------------------------------------------------
	localparam int         CLK_MHZ    = 100;
	localparam int         CE_MIN_US  = 10;
	localparam int         CE_MIN_CYC = CE_MIN_US * CLK_MHZ;
	localparam int         CE_CNT_W   = 10;

	// ----------------------------------------------------------------
	// Host commands and load states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		RPFS_CMD_NOP,
		RPFS_CMD_WR_TX,
		RPFS_CMD_RD_RX,
		RPFS_CMD_FLUSH_TX,
		RPFS_CMD_FLUSH_RX,
		RPFS_CMD_REUSE_TX,
		RPFS_CMD_WR_ACK,
		RPFS_CMD_WR_STATUS
	} rpfs_cmd_t;

	typedef enum logic {
		RPFS_IDLE,
		RPFS_LOAD
	} rpfs_state_t;

endpackage

//--- src/rpfs_stage_if.sv
`timescale 1ns/10ps
// Carrier between the core and its staging buffer
interface rpfs_stage_if #(
	parameter int WIDTH = 9
);
	logic             in_valid;  // Fill side offers a word
	logic             in_ready;  // Buffer has room
	logic [WIDTH-1:0] in_data;   // Word being filled
	logic             out_valid; // Buffer holds a word
	logic             out_ready; // Drain side takes it
	logic [WIDTH-1:0] out_data;  // Oldest word
	logic             flush;     // Drop all contents

	modport buf_side (
		input  in_valid, in_data, out_ready, flush,
		output in_ready, out_valid, out_data
	);
	modport user_side (
		output in_valid, in_data, out_ready, flush,
		input  in_ready, out_valid, out_data
	);
endinterface

//--- src/rpfs_stage_fifo.sv
`timescale 1ns/10ps
// Staging buffer, first in first out
module rpfs_stage_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic        core_clk,
	input wire logic        rst,
	rpfs_stage_if.buf_side  stg
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];            // Word storage
	logic [AW-1:0]    wr_ptr, next_wr_ptr;    // Write position
	logic [AW-1:0]    rd_ptr, next_rd_ptr;    // Read position
	logic [AW:0]      count, next_count;      // Words held
	logic             push;                   // Word taken in
	logic             pop;                    // Word handed out

	// Honest flags straight from the count
	assign stg.in_ready  = (count != (AW+1)'(DEPTH));
	assign stg.out_valid = (count != '0);
	assign stg.out_data  = mem[rd_ptr];
	assign push          = stg.in_valid & stg.in_ready;
	assign pop           = stg.out_valid & stg.out_ready;

	// ----------------------------------------------------------------
	// Pointer and count update
	// ----------------------------------------------------------------
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (stg.flush) begin
			// Flush wins over any transfer this cycle
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end else begin
			if (push) begin
				next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				next_count = count + 1'b1;
			end else if (pop && !push) begin
				next_count = count - 1'b1;
			end
		end
	end

	// Registers; storage needs no reset
	always_ff @(posedge core_clk) begin
		if (push && !stg.flush) begin
			mem[wr_ptr] <= stg.in_data;
		end
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

endmodule

//--- verification/rpfs_core_props.sv
`timescale 1ns/10ps
// Port-level watcher for the payload FIFO status core
module rpfs_core_props (
	input wire logic                core_clk,
	input wire logic                rst,
	input wire logic                primary_transmitter_role,
	input wire logic                chip_enable,
	input wire logic                host_cmd_valid,
	input wire rpfs_pkg::rpfs_cmd_t host_cmd,
	input wire logic                host_data_ready,
	input wire logic [7:0]          status,
	input wire logic                link_tx_done,
	input wire logic                link_reuse,
	input wire logic                link_retransmit,
	input wire logic                link_rx_push,
	input wire logic                link_ack_req,
	input wire logic [2:0]          link_ack_pipe,
	input wire logic                link_ack_attach,
	input wire logic [2:0]          link_ack_attach_pipe
);
	default clocking cb @(posedge core_clk); endclocking

	// ------------------------------------------------------------
	// Reuse hold counter
	// ------------------------------------------------------------
	logic [10:0] hold_cnt;      // Cycles all reuse terms held
	logic [10:0] next_hold_cnt; // Saturates, so no wrap hides a late pulse

	// Restart on any dropped term
	always_comb begin
		next_hold_cnt = hold_cnt;
		if (rst || !(chip_enable && primary_transmitter_role && link_reuse)) begin
			next_hold_cnt = 11'h000;
		end else if (hold_cnt != 11'h7FF) begin
			next_hold_cnt = hold_cnt + 11'h001;
		end
	end

	// Register only
	always_ff @(posedge core_clk) begin
		hold_cnt <= next_hold_cnt;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_reset_status: assert property (disable iff (rst)
		$fell(rst) |-> status == 8'h11 && !host_data_ready) else $error("bad reset status");
	a_flush_tx_empty: assert property (disable iff (rst)
		host_cmd_valid && host_cmd == rpfs_pkg::RPFS_CMD_FLUSH_TX |=> status[5:4] == 2'h1)
		else $error("tx flags wrong after flush");
	a_flush_rx_empty: assert property (disable iff (rst)
		host_cmd_valid && host_cmd == rpfs_pkg::RPFS_CMD_FLUSH_RX |=> status[1:0] == 2'h1)
		else $error("rx flags wrong after flush");
	a_full_refuses: assert property (disable iff (rst)
		status[5] && !link_tx_done && host_cmd_valid && host_cmd == rpfs_pkg::RPFS_CMD_WR_TX
		|=> !host_data_ready [*2]) else $error("payload load taken while full");
	a_reuse_ends: assert property (disable iff (rst)
		host_cmd_valid && host_cmd inside {rpfs_pkg::RPFS_CMD_WR_TX, rpfs_pkg::RPFS_CMD_FLUSH_TX}
		|=> !link_reuse && !status[6]) else $error("reuse not ended");
	a_reuse_holds: assert property (disable iff (rst)
		link_reuse && !(host_cmd_valid && host_cmd inside {rpfs_pkg::RPFS_CMD_WR_TX,
		rpfs_pkg::RPFS_CMD_FLUSH_TX}) |=> link_reuse) else $error("reuse dropped early");
	a_retx_after_hold: assert property (disable iff (rst)
		link_retransmit |-> hold_cnt >= 11'h3E8) else $error("retransmit before hold time");
	a_retx_single: assert property (disable iff (rst)
		link_retransmit |=> !link_retransmit) else $error("retransmit longer than a pulse");
	a_ack_pipe_match: assert property (disable iff (rst)
		link_ack_attach |-> $past(link_ack_req) && link_ack_attach_pipe == $past(link_ack_pipe))
		else $error("ack attach without matching request");
	a_rx_push_flag: assert property (disable iff (rst)
		link_rx_push && status[0] && !(host_cmd_valid && host_cmd == rpfs_pkg::RPFS_CMD_FLUSH_RX)
		|=> !status[0]) else $error("rx empty flag stale");
endmodule

//--- verification/rpfs_host_model.sv
`timescale 1ns/10ps
// Host model: command strobes and payload bytes
module rpfs_host_model (
	input  wire logic           core_clk,
	input  wire logic           host_data_ready,
	output logic                host_cmd_valid,
	output rpfs_pkg::rpfs_cmd_t host_cmd,
	output logic [2:0]          ack_pipe_number,
	output logic [7:0]          host_cmd_wdata,
	output logic                host_data_valid,
	output logic [7:0]          host_data,
	output logic                host_data_last
);
	// Idle levels from time zero
	initial begin
		host_cmd_valid = 1'h0;
		host_cmd = rpfs_pkg::RPFS_CMD_NOP;
		ack_pipe_number = 3'h0;
		host_cmd_wdata = 8'h00;
		host_data_valid = 1'h0;
		host_data = 8'h00;
		host_data_last = 1'h0;
	end

	task automatic cmd(input rpfs_pkg::rpfs_cmd_t c, input logic [2:0] pipe);
		@(posedge core_clk);
		host_cmd_valid <= 1'h1;
		host_cmd <= c;
		ack_pipe_number <= pipe;
		host_cmd_wdata <= 8'h00;
		@(posedge core_clk);
		host_cmd_valid <= 1'h0;
	endtask

	// one entry of 1 or more bytes
	task automatic send_payload(input logic [7:0] b[$]);
		int n;
		for (int i = 0; i < b.size(); i++) begin
			host_data_valid <= 1'h1;
			host_data <= b[i];
			host_data_last <= (i == b.size() - 1);
			n = 0;
			// Byte held until ready seen high
			do begin
				@(posedge core_clk);
				n++;
			end while (host_data_ready !== 1'h1 && n < 200);
		end
		host_data_valid <= 1'h0;
		host_data <= ~b[b.size() - 1]; // Released line shows no stale byte
		host_data_last <= 1'h0;
	endtask
endmodule

//--- verification/rpfs_core_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the payload FIFO status core
module rpfs_core_tb;
	logic                core_clk, rst, primary_transmitter_role, chip_enable;
	logic                host_cmd_valid, host_data_valid, host_data_last, host_data_ready;
	rpfs_pkg::rpfs_cmd_t host_cmd;
	logic [2:0]          ack_pipe_number, link_ack_pipe, link_ack_attach_pipe;
	logic [7:0]          host_cmd_wdata, host_data, status, link_tx_data;
	logic                link_tx_valid, link_tx_last, link_tx_ready, link_tx_done;
	logic                link_reuse, link_retransmit, link_rx_push;
	logic                link_ack_req, link_ack_attach;
	logic [8:0]          exp_q[$];         // Expected {last, byte} on the link
	int                  bad_count;        // Mismatches
	int                  samples_checked;  // Comparisons

	rpfs_core i_rpfs_core (.core_clk(core_clk), .rst(rst),
		.primary_transmitter_role(primary_transmitter_role), .chip_enable(chip_enable),
		.host_cmd_valid(host_cmd_valid), .host_cmd(host_cmd), .ack_pipe_number(ack_pipe_number),
		.host_cmd_wdata(host_cmd_wdata), .host_data_valid(host_data_valid),
		.host_data(host_data), .host_data_last(host_data_last),
		.host_data_ready(host_data_ready), .status(status), .link_tx_valid(link_tx_valid),
		.link_tx_data(link_tx_data), .link_tx_last(link_tx_last),
		.link_tx_ready(link_tx_ready), .link_tx_done(link_tx_done), .link_reuse(link_reuse),
		.link_retransmit(link_retransmit), .link_rx_push(link_rx_push),
		.link_ack_req(link_ack_req), .link_ack_pipe(link_ack_pipe),
		.link_ack_attach(link_ack_attach), .link_ack_attach_pipe(link_ack_attach_pipe));

	rpfs_host_model i_rpfs_host_model (.*);

	// ------------------------------------------------------------
	// Clock, helpers, verdict
	// ------------------------------------------------------------
	initial core_clk = 1'h0;
	always #5 core_clk = ~core_clk;

	// Link stalls at random
	always @(posedge core_clk) link_tx_ready <= 1'($urandom);

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Flags settle one edge after the cause; checked two edges later
	task automatic chk_status(input logic [7:0] exp);
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		check("status", {1'h0, status}, {1'h0, exp});
	endtask

	// One-cycle pulse of {done, push, ack request}
	task automatic link_pulse(input logic [2:0] sel, input logic [2:0] pipe);
		@(posedge core_clk);
		{link_tx_done, link_rx_push, link_ack_req} <= sel;
		link_ack_pipe <= pipe;
		@(posedge core_clk);
		{link_tx_done, link_rx_push, link_ack_req} <= 3'h0;
		link_ack_pipe <= ~pipe;
	endtask

	// Random payload, noted in the queue
	task automatic load_payload(input int n);
		logic [7:0] pl[$];
		for (int k = 0; k < n; k++) begin
			pl.push_back(8'($urandom));
			// Bytes past 32 are swallowed; byte 32 closes the entry
			if (k < 32) exp_q.push_back({k == n - 1 || k == 31, pl[k]});
		end
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_WR_TX, 3'h0);
		i_rpfs_host_model.send_payload(pl);
	endtask

	always @(posedge core_clk) begin
		if (!rst && link_tx_valid === 1'h1 && link_tx_ready === 1'h1) begin
			if (exp_q.size() == 0) check("tx_extra", 9'h000, 9'h1FF);
			else check("tx_byte", {link_tx_last, link_tx_data}, exp_q.pop_front());
		end
	end

	// Watchdog well past the expected run
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		finish_test();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		int n;
		logic got;
		logic [2:0] gpipe;
		void'($urandom(14));
		rst = 1'h1;
		primary_transmitter_role = 1'h1;
		chip_enable = 1'h0;
		{link_tx_done, link_rx_push, link_ack_req, link_ack_pipe} = 6'h00;
		bad_count = 0;
		samples_checked = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'h0;
		chk_status(8'h11);
		// Fill all three entries; the second runs past the byte cap
		for (int i = 0; i < 3; i++) begin
			load_payload((i == 0) ? 1 : (i == 1) ? 34 : 1 + int'($urandom % 32));
			chk_status((i == 2) ? 8'h21 : 8'h01);
		end
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_WR_TX, 3'h0);
		chk_status(8'h21);
		n = 0;
		while (exp_q.size() != 0 && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		check("drained", 9'(exp_q.size()), 9'h000);
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_REUSE_TX, 3'h0);
		chk_status(8'h61);
		link_pulse(3'h4, 3'h0);
		chk_status(8'h61);
		@(posedge core_clk);
		chip_enable <= 1'h1;
		n = 0;
		got = 1'h0;
		while (!got && n < 1200) begin
			@(negedge core_clk);
			got = (link_retransmit === 1'h1);
			n++;
		end
		check("retx_seen", {8'h00, got}, 9'h001);
		check("retx_late", {8'h00, n > 1000}, 9'h001);
		@(posedge core_clk);
		chip_enable <= 1'h0;
		primary_transmitter_role <= 1'h0;
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_FLUSH_TX, 3'h0);
		chk_status(8'h11);
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_REUSE_TX, 3'h0);
		chk_status(8'h11);
		@(posedge core_clk);
		primary_transmitter_role <= 1'h1;
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_REUSE_TX, 3'h0);
		load_payload(1);
		chk_status(8'h01);
		link_pulse(3'h4, 3'h0);
		chk_status(8'h11);
		// Receive side, one push past full is dropped
		for (int i = 1; i <= 4; i++) begin
			link_pulse(3'h2, 3'h0);
			chk_status((i >= 3) ? 8'h12 : 8'h10);
		end
		for (int i = 2; i >= 0; i--) begin
			i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_RD_RX, 3'h0);
			chk_status((i == 0) ? 8'h11 : 8'h10);
		end
		link_pulse(3'h2, 3'h0);
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_FLUSH_RX, 3'h0);
		chk_status(8'h11);
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_NOP, 3'h0);
		i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_WR_STATUS, 3'h0);
		chk_status(8'h11);
		// Every pipe, then a second request with nothing loaded
		for (int p = 0; p < 8; p++) begin
			i_rpfs_host_model.cmd(rpfs_pkg::RPFS_CMD_WR_ACK, 3'(p));
			for (int j = 0; j < 2; j++) begin
				link_pulse(3'h1, 3'(p));
				got = 1'h0;
				repeat (2) begin
					@(negedge core_clk);
					if (link_ack_attach === 1'h1) begin
						got = 1'h1;
						gpipe = link_ack_attach_pipe;
					end
				end
				check("ack_attach", {8'h00, got}, {8'h00, p < 6 && j == 0});
				if (got) check("ack_pipe", {6'h00, gpipe}, 9'(p));
			end
		end
		finish_test();
	end
endmodule

bind rpfs_core rpfs_core_props i_rpfs_core_props (.*);
